// file: bench/pma_blk_model.sv
/*
  Behavioural stand-in for the external register blocks behind the map.
  Assumes per_q comes straight from pma_top and that a block must answer
  within the cycle in which its select is high.
*/
`timescale 1ns/10ps
`default_nettype none
module pma_blk_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire pma_pkg::pma_per_t per_q,
  output var logic [31:0] per_rdata
);
  logic [31:0] last_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      last_q <= 32'h0000_0000;
    end else begin
      last_q <= per_rdata;
    end
  end

  // The answer names the selected block and echoes the offset. An idle bus
  // shows the inverse of the last value, so data sampled one cycle late cannot match.
  always_comb begin
    if (per_q.sel != 5'h00) begin
      per_rdata = {8'hC0, 3'h0, per_q.sel, 8'h00, per_q.offset};
    end else begin
      per_rdata = ~last_q;
    end
  end
endmodule
`default_nettype wire

// file: bench/pma_top_bench.sv
/*
  Self-checking bench of the peripheral map access controller.
  Assumes pma_pkg and pma_regs.svh are compiled first and that the block
  model stands in for every external register block.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pma_regs.svh"
module pma_top_bench;
  typedef struct packed {
    logic [31:0] addr;
    logic wr;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [4:0] sel;
  } pma_row_t;

  localparam int NROW = 16;
  localparam pma_row_t ROWS [NROW] = '{
    '{32'h4000_1004, 1'b0, 32'h0000_0000, 32'hC001_0004, 5'h01},
    '{32'h4000_E010, 1'b0, 32'h0000_0000, 32'hC002_0010, 5'h02},
    '{32'h4000_FC20, 1'b0, 32'h0000_0000, 32'hC004_0020, 5'h04},
    '{32'h4008_0108, 1'b1, 32'h1234_5678, 32'h0000_0000, 5'h08},
    '{32'h4000_AEFC, 1'b0, 32'h0000_0000, 32'hC010_00FC, 5'h10},
    '{32'h4000_0400, 1'b0, 32'h0000_0000, 32'h0000_0000, 5'h00},
    '{32'h4000_0400, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000, 5'h00},
    '{32'h400F_FF00, 1'b0, 32'h0000_0000, 32'h0000_003F, 5'h00},
    '{32'h400F_FF00, 1'b1, 32'h0000_00FF, 32'h0000_0000, 5'h00},
    '{32'h400F_FF00, 1'b0, 32'h0000_0000, 32'h0000_003F, 5'h00},
    '{32'h400F_FF04, 1'b1, 32'hFFFF_FFA5, 32'h0000_0000, 5'h00},
    '{32'h400F_FF04, 1'b0, 32'h0000_0000, 32'h0000_00A5, 5'h00},
    '{32'h400F_FF08, 1'b1, 32'h0000_0077, 32'h0000_0000, 5'h00},
    '{32'h400F_FF08, 1'b0, 32'h0000_0000, 32'h0000_0000, 5'h00},
    '{32'h400F_FF24, 1'b0, 32'h0000_0000, 32'h0000_0000, 5'h00},
    '{32'h400F_FF02, 1'b0, 32'h0000_0000, 32'h0000_0000, 5'h00}
  };

  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  pma_pkg::pma_req_t cpu_req = '0;
  pma_pkg::pma_req_t dbg_req = '0;
  pma_pkg::pma_rsp_t cpu_rsp_q;
  pma_pkg::pma_rsp_t dbg_rsp_q;
  pma_pkg::pma_per_t per_q;
  logic [31:0] per_rdata;
  logic [7:0] evt_set = 8'h00;
  logic [7:0] evt_clr = 8'h00;
  logic sem_release = 1'b0;
  logic [`PMA_GCFG_NREG-1:0][7:0] gcfg_fields_q;
  int num_errors = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic [4:0] sel;
  logic [4:0] sel2;
  time t1;
  time t2;

  always #50 clk_sys = ~clk_sys;

  pma_top #(.FW(8)) dut_u (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cpu_req(cpu_req),
    .dbg_req(dbg_req),
    .cpu_rsp_q(cpu_rsp_q),
    .dbg_rsp_q(dbg_rsp_q),
    .per_q(per_q),
    .per_rdata(per_rdata),
    .evt_set(evt_set),
    .evt_clr(evt_clr),
    .sem_release(sem_release),
    .gcfg_fields_q(gcfg_fields_q)
  );

  pma_blk_model blk_u (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .per_q(per_q),
    .per_rdata(per_rdata)
  );

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_fld(input int idx, input logic [7:0] exp);
    comparisons++;
    if (gcfg_fields_q[idx] !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, gcfg_fields_q[idx], exp);
    end
  endtask

  // One whole access; valid stays up until done has been seen, as the
  // controller refuses nothing but takes nothing while busy.
  task automatic acc(input bit dbg, input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rdat,
                     output logic [4:0] sl, output time t);
    pma_pkg::pma_req_t r;
    pma_pkg::pma_rsp_t s;
    int n;
    @(negedge clk_sys);
    r = '{1'b1, wr, a, wd};
    if (dbg) dbg_req = r;
    else cpu_req = r;
    sl = 5'h00;
    n = 0;
    do begin
      @(negedge clk_sys);
      sl = sl | per_q.sel;
      s = dbg ? dbg_rsp_q : cpu_rsp_q;
      n++;
    end while (s.done !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    rdat = s.rdata;
    t = $time;
    r.valid = 1'b0;
    if (dbg) dbg_req = r;
    else cpu_req = r;
  endtask

  task automatic pulse(input logic [7:0] st, input logic [7:0] cl, input logic sr);
    @(negedge clk_sys);
    evt_set = st;
    evt_clr = cl;
    sem_release = sr;
    @(negedge clk_sys);
    evt_set = 8'h00;
    evt_clr = 8'h00;
    sem_release = 1'b0;
  endtask

  task automatic close_out;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #(100 * 3000);
    num_errors++;
    close_out();
  end

  initial begin
    repeat (8) @(negedge clk_sys);
    chk_word({27'h0, per_q.sel}, 32'h0000_0000);
    chk_fld(0, 8'h3F);
    chk_fld(4, 8'h00);
    rst_b = 1'b1;
    $display("test reset done");
    for (int i = 0; i < NROW; i++) begin
      acc(1'b0, ROWS[i].wr, ROWS[i].addr, ROWS[i].wd, rd, sel, t1);
      chk_word(rd, ROWS[i].rd);
      chk_word({27'h0, sel}, {27'h0, ROWS[i].sel});
    end
    chk_fld(2, 8'h77);
    chk_fld(0, 8'h3F);
    $display("test table done");
    acc(1'b0, 1'b0, 32'h400F_FF0C, 32'h0, rd, sel, t1);
    chk_word(rd, 32'h0000_0000);
    chk_fld(3, 8'hFF);
    pulse(8'h00, 8'h00, 1'b1);
    chk_fld(3, 8'h00);
    pulse(8'h3C, 8'h00, 1'b0);
    acc(1'b0, 1'b1, 32'h400F_FF10, 32'h0000_00FF, rd, sel, t1);
    chk_fld(4, 8'h3C);
    acc(1'b0, 1'b0, 32'h400F_FF10, 32'h0, rd, sel, t1);
    chk_word(rd, 32'h0000_003C);
    chk_fld(4, 8'h00);
    acc(1'b0, 1'b1, 32'h400F_FF14, 32'h0000_000C, rd, sel, t1);
    chk_fld(5, 8'h30);
    acc(1'b0, 1'b1, 32'h400F_FF18, 32'h0000_00F3, rd, sel, t1);
    chk_fld(6, 8'h30);
    acc(1'b0, 1'b1, 32'h400F_FF1C, 32'h0000_0081, rd, sel, t1);
    acc(1'b0, 1'b1, 32'h400F_FF1C, 32'h0000_0000, rd, sel, t1);
    chk_fld(7, 8'h81);
    acc(1'b0, 1'b1, 32'h400F_FF20, 32'h0000_00FE, rd, sel, t1);
    chk_fld(8, 8'h01);
    pulse(8'h00, 8'hFF, 1'b0);
    chk_fld(7, 8'h00);
    $display("test fields done");
    acc(1'b1, 1'b0, 32'h4000_AE08, 32'h0, rd, sel, t1);
    chk_word(rd, 32'hC010_0008);
    acc(1'b1, 1'b1, 32'h400F_FF04, 32'h0000_005A, rd, sel, t1);
    chk_fld(1, 8'h5A);
    $display("test debug done");
    fork
      acc(1'b0, 1'b0, 32'h4000_1008, 32'h0, rd, sel, t1);
      acc(1'b1, 1'b0, 32'h4000_FC04, 32'h0, rd2, sel2, t2);
    join
    chk_word(rd, 32'hC001_0008);
    chk_word(rd2, 32'hC004_0004);
    chk_word({31'h0, t1 != t2}, 32'h0000_0001);
    $display("test contention done");
    close_out();
  end
endmodule
`default_nettype wire

// file: rtl/pma_field.sv
/*
  One register field with a selectable access kind.
  Assumes the strobes are one-cycle pulses from the access controller.
*/
`timescale 1ns/10ps
`default_nettype none
module pma_field #(
  parameter int W = 8,
  parameter pma_pkg::pma_acc_t ACC = pma_pkg::PMA_ACC_RW,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wr,
  input wire logic rd,
  input wire logic [W-1:0] wdata,
  input wire logic [W-1:0] hw_set,
  input wire logic [W-1:0] hw_clr,
  output var logic [W-1:0] value_q
);

  logic [W-1:0] value_d;

  // Hardware set events are merged last so that they win over any clear.
  always_comb begin
    value_d = value_q;
    unique case (ACC)
      pma_pkg::PMA_ACC_RW, pma_pkg::PMA_ACC_WO: begin
        if (wr) begin
          value_d = wdata;
        end
      end
      pma_pkg::PMA_ACC_RO: begin
        value_d = value_q;
      end
      pma_pkg::PMA_ACC_RS: begin
        value_d = value_q & ~hw_clr;
        if (rd) begin
          value_d = '1;
        end
      end
      pma_pkg::PMA_ACC_RC: begin
        if (rd) begin
          value_d = '0;
        end
        value_d = value_d | hw_set;
      end
      pma_pkg::PMA_ACC_W1C: begin
        if (wr) begin
          value_d = value_q & ~wdata;
        end
        value_d = value_d | hw_set;
      end
      pma_pkg::PMA_ACC_WZC: begin
        if (wr) begin
          value_d = value_q & wdata;
        end
        value_d = value_d | hw_set;
      end
      pma_pkg::PMA_ACC_W1S: begin
        value_d = value_q & ~hw_clr;
        if (wr) begin
          value_d = value_d | wdata;
        end
      end
      pma_pkg::PMA_ACC_WZS: begin
        value_d = value_q & ~hw_clr;
        if (wr) begin
          value_d = value_d | ~wdata;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      value_q <= RST;
    end else begin
      value_q <= value_d;
    end
  end

endmodule
`default_nettype wire

// file: rtl/pma_pkg.sv
/*
  Types of the peripheral map access block: requests, answers, the
  peripheral strobe group, block identities and field access kinds.
  Assumes pma_regs.svh is on the include path.
*/
`default_nettype none
`include "pma_regs.svh"
package pma_pkg;

  typedef enum logic [2:0] {
    PMA_BLK_NONE, PMA_BLK_CCT, PMA_BLK_IA, PMA_BLK_ECS, PMA_BLK_PCR, PMA_BLK_VCI,
    PMA_BLK_GCFG
  } pma_blk_t;

  typedef enum logic [3:0] {
    PMA_ACC_RW, PMA_ACC_RO, PMA_ACC_WO, PMA_ACC_RS, PMA_ACC_RC,
    PMA_ACC_W1C, PMA_ACC_WZC, PMA_ACC_W1S, PMA_ACC_WZS
  } pma_acc_t;

  localparam pma_acc_t PMA_ACC_TAB [`PMA_GCFG_NREG] = '{
    PMA_ACC_RO, PMA_ACC_RW, PMA_ACC_WO, PMA_ACC_RS, PMA_ACC_RC,
    PMA_ACC_W1C, PMA_ACC_WZC, PMA_ACC_W1S, PMA_ACC_WZS
  };

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pma_req_t;

  typedef struct packed {
    logic done;
    logic [31:0] rdata;
  } pma_rsp_t;

  typedef struct packed {
    logic [`PMA_NUM_EXT-1:0] sel;
    logic write;
    logic [7:0] offset;
    logic [31:0] wdata;
  } pma_per_t;

endpackage
`default_nettype wire

// file: rtl/pma_regs.svh
/*
  Constants of the peripheral map access block: block base addresses, the
  decode window, the local configuration register indices and reset values.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef PMA_REGS_SVH
`define PMA_REGS_SVH

`define PMA_BASE_CCT 32'h4000_1000
`define PMA_BASE_IA 32'h4000_E000
`define PMA_BASE_ECS 32'h4000_FC00
`define PMA_BASE_PCR 32'h4008_0100
`define PMA_BASE_VCI 32'h4000_AE00
`define PMA_BASE_GCFG 32'h400F_FF00
`define PMA_BLK_MASK 32'hFFFF_FF00

`define PMA_NUM_EXT 5
`define PMA_SEL_CCT 0
`define PMA_SEL_IA 1
`define PMA_SEL_ECS 2
`define PMA_SEL_PCR 3
`define PMA_SEL_VCI 4

`define PMA_GCFG_NREG 9
`define PMA_IDX_LDN 0
`define PMA_IDX_CTRL 1
`define PMA_IDX_WO 2
`define PMA_IDX_RS 3
`define PMA_IDX_RC 4
`define PMA_IDX_W1C 5
`define PMA_IDX_WZC 6
`define PMA_IDX_W1S 7
`define PMA_IDX_WZS 8
`define PMA_LDN_VAL 8'h3F

`endif

// file: rtl/pma_top.sv
/*
  Peripheral map access controller: arbitrates the processor and debug
  requesters, decodes the block base map, forwards accesses to external
  blocks and hosts the global configuration fields locally.
  Assumes each requester holds valid until it sees done, and that an
  external block answers per_rdata within the cycle its select is high.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pma_regs.svh"
module pma_top #(
  parameter int FW = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire pma_pkg::pma_req_t cpu_req,
  input wire pma_pkg::pma_req_t dbg_req,
  output var pma_pkg::pma_rsp_t cpu_rsp_q,
  output var pma_pkg::pma_rsp_t dbg_rsp_q,
  output var pma_pkg::pma_per_t per_q,
  input wire logic [31:0] per_rdata,
  input wire logic [FW-1:0] evt_set,
  input wire logic [FW-1:0] evt_clr,
  input wire logic sem_release,
  output var logic [`PMA_GCFG_NREG-1:0][FW-1:0] gcfg_fields_q
);

  // The only requesters are the processor and the debug port; a serial
  // host has no port here and must go through processor firmware.
  localparam int NREG = `PMA_GCFG_NREG;

  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_CLOSE} pma_state_t;

  pma_state_t state_q;
  pma_pkg::pma_req_t cur_q;
  pma_pkg::pma_blk_t blk_q;
  logic owner_dbg_q;
  logic last_dbg_q;

  logic gnt_any;
  logic gnt_dbg;
  pma_pkg::pma_req_t gnt_req;
  pma_pkg::pma_blk_t gnt_blk;
  logic [5:0] idx;
  logic idx_ok;
  logic loc_acc;
  logic loc_wr;
  logic loc_rd;
  logic [31:0] loc_rdata;
  logic [31:0] rd_data;

  function automatic pma_pkg::pma_blk_t blk_decode(input logic [31:0] addr);
    logic [31:0] base;
    base = addr & `PMA_BLK_MASK;
    if (base == `PMA_BASE_CCT) begin
      blk_decode = pma_pkg::PMA_BLK_CCT;
    end else if (base == `PMA_BASE_IA) begin
      blk_decode = pma_pkg::PMA_BLK_IA;
    end else if (base == `PMA_BASE_ECS) begin
      blk_decode = pma_pkg::PMA_BLK_ECS;
    end else if (base == `PMA_BASE_PCR) begin
      blk_decode = pma_pkg::PMA_BLK_PCR;
    end else if (base == `PMA_BASE_VCI) begin
      blk_decode = pma_pkg::PMA_BLK_VCI;
    end else if (base == `PMA_BASE_GCFG) begin
      blk_decode = pma_pkg::PMA_BLK_GCFG;
    end else begin
      blk_decode = pma_pkg::PMA_BLK_NONE;
    end
  endfunction

  function automatic logic [`PMA_NUM_EXT-1:0] blk_onehot(input pma_pkg::pma_blk_t blk);
    blk_onehot = '0;
    unique case (blk)
      pma_pkg::PMA_BLK_CCT: blk_onehot[`PMA_SEL_CCT] = 1'b1;
      pma_pkg::PMA_BLK_IA: blk_onehot[`PMA_SEL_IA] = 1'b1;
      pma_pkg::PMA_BLK_ECS: blk_onehot[`PMA_SEL_ECS] = 1'b1;
      pma_pkg::PMA_BLK_PCR: blk_onehot[`PMA_SEL_PCR] = 1'b1;
      pma_pkg::PMA_BLK_VCI: blk_onehot[`PMA_SEL_VCI] = 1'b1;
      pma_pkg::PMA_BLK_NONE, pma_pkg::PMA_BLK_GCFG: blk_onehot = '0;
      default: blk_onehot = '0;
    endcase
  endfunction

  // When both ask at once the one not served last wins, so the debug port
  // cannot be starved by a busy processor and vice versa.
  assign gnt_any = cpu_req.valid | dbg_req.valid;
  assign gnt_dbg = dbg_req.valid & (~cpu_req.valid | ~last_dbg_q);
  assign gnt_req = gnt_dbg ? dbg_req : cpu_req;
  assign gnt_blk = blk_decode(gnt_req.addr);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (gnt_any) begin
            state_q <= ST_XFER;
          end
        end
        ST_XFER: state_q <= ST_CLOSE;
        ST_CLOSE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // The request is captured once so that a requester changing its lines
  // mid-access cannot corrupt the access in flight.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cur_q <= '0;
      blk_q <= pma_pkg::PMA_BLK_NONE;
      owner_dbg_q <= 1'b0;
      last_dbg_q <= 1'b0;
    end else if (state_q == ST_IDLE && gnt_any) begin
      cur_q <= gnt_req;
      blk_q <= gnt_blk;
      owner_dbg_q <= gnt_dbg;
      last_dbg_q <= gnt_dbg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      per_q <= '0;
    end else if (state_q == ST_IDLE && gnt_any) begin
      per_q.sel <= blk_onehot(gnt_blk);
      per_q.write <= gnt_req.write;
      per_q.offset <= gnt_req.addr[7:0];
      per_q.wdata <= gnt_req.wdata;
    end else begin
      per_q.sel <= '0;
    end
  end

  assign idx = cur_q.addr[7:2];
  assign idx_ok = (cur_q.addr[1:0] == 2'h0) && (idx < 6'(NREG));
  assign loc_acc = (state_q == ST_XFER) && (blk_q == pma_pkg::PMA_BLK_GCFG) && idx_ok;
  assign loc_wr = loc_acc && cur_q.write;
  assign loc_rd = loc_acc && !cur_q.write;

  // Upper bits above the field width are reserved and read as zero.
  always_comb begin
    loc_rdata = '0;
    for (int i = 0; i < NREG; i++) begin
      if (idx_ok && idx == 6'(i) && pma_pkg::PMA_ACC_TAB[i] != pma_pkg::PMA_ACC_WO) begin
        loc_rdata[FW-1:0] = gcfg_fields_q[i];
      end
    end
  end

  always_comb begin
    rd_data = '0;
    if (!cur_q.write) begin
      if (blk_q == pma_pkg::PMA_BLK_GCFG) begin
        rd_data = loc_rdata;
      end else if (blk_q != pma_pkg::PMA_BLK_NONE) begin
        rd_data = per_rdata;
      end else begin
        rd_data = '0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cpu_rsp_q <= '0;
      dbg_rsp_q <= '0;
    end else if (state_q == ST_XFER) begin
      cpu_rsp_q.done <= !owner_dbg_q;
      dbg_rsp_q.done <= owner_dbg_q;
      cpu_rsp_q.rdata <= rd_data;
      dbg_rsp_q.rdata <= rd_data;
    end else begin
      cpu_rsp_q.done <= 1'b0;
      dbg_rsp_q.done <= 1'b0;
    end
  end

  for (genvar i = 0; i < NREG; i++) begin : g_fld
    localparam pma_pkg::pma_acc_t ACC = pma_pkg::PMA_ACC_TAB[i];
    logic [FW-1:0] set_v;
    logic [FW-1:0] clr_v;
    // Event inputs feed only the flag-like fields; hardware never alters
    // the read-only identity field.
    assign set_v = (ACC == pma_pkg::PMA_ACC_RC || ACC == pma_pkg::PMA_ACC_W1C ||
                    ACC == pma_pkg::PMA_ACC_WZC) ? evt_set : '0;
    assign clr_v = (ACC == pma_pkg::PMA_ACC_W1S || ACC == pma_pkg::PMA_ACC_WZS) ? evt_clr :
                   (ACC == pma_pkg::PMA_ACC_RS) ? {FW{sem_release}} : '0;
    pma_field #(
      .W(FW),
      .ACC(ACC),
      .RST((i == `PMA_IDX_LDN) ? FW'(`PMA_LDN_VAL) : '0)
    ) u_fld (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .wr(loc_wr && idx == 6'(i)),
      .rd(loc_rd && idx == 6'(i)),
      .wdata(cur_q.wdata[FW-1:0]),
      .hw_set(set_v),
      .hw_clr(clr_v),
      .value_q(gcfg_fields_q[i])
    );
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  logic take;
  assign take = (state_q == ST_IDLE) && gnt_any;

  chk_resv_read_zero: assert property (
    (state_q == ST_XFER && blk_q == pma_pkg::PMA_BLK_NONE && !cur_q.write)
      |=> (cpu_rsp_q.rdata == 32'h0000_0000 && dbg_rsp_q.rdata == 32'h0000_0000))
    else $error("reserved read returned nonzero data");

  chk_resv_no_strobe: assert property (
    (take && gnt_blk == pma_pkg::PMA_BLK_NONE) |=> (per_q.sel == '0) [*3])
    else $error("reserved access reached a peripheral");

  chk_ldn_constant: assert property (
    gcfg_fields_q[`PMA_IDX_LDN] == FW'(`PMA_LDN_VAL))
    else $error("logical device number field changed");

  chk_wo_reads_zero: assert property (
    (loc_rd && idx == 6'(`PMA_IDX_WO)) |=> cpu_rsp_q.rdata == 32'h0000_0000)
    else $error("write-only field read back nonzero");

  chk_rs_sets: assert property (
    (loc_rd && idx == 6'(`PMA_IDX_RS)) |=> gcfg_fields_q[`PMA_IDX_RS] == '1)
    else $error("read-sets field not set after read");

  chk_rc_clears: assert property (
    (loc_acc && idx == 6'(`PMA_IDX_RC) && evt_set == '0)
      |=> (gcfg_fields_q[`PMA_IDX_RC] == (cur_q.write ? $past(gcfg_fields_q[`PMA_IDX_RC]) : '0)))
    else $error("read-clears field misbehaved");

  chk_w1c_update: assert property (
    (loc_wr && idx == 6'(`PMA_IDX_W1C) && evt_set == '0) |=> gcfg_fields_q[`PMA_IDX_W1C] ==
      ($past(gcfg_fields_q[`PMA_IDX_W1C]) & ~$past(cur_q.wdata[FW-1:0])))
    else $error("write-one-clears update wrong");

  chk_wzc_update: assert property (
    (loc_wr && idx == 6'(`PMA_IDX_WZC) && evt_set == '0) |=> gcfg_fields_q[`PMA_IDX_WZC] ==
      ($past(gcfg_fields_q[`PMA_IDX_WZC]) & $past(cur_q.wdata[FW-1:0])))
    else $error("write-zero-clears update wrong");

  chk_w1s_update: assert property (
    (loc_wr && idx == 6'(`PMA_IDX_W1S) && evt_clr == '0) |=> gcfg_fields_q[`PMA_IDX_W1S] ==
      ($past(gcfg_fields_q[`PMA_IDX_W1S]) | $past(cur_q.wdata[FW-1:0])))
    else $error("write-one-sets update wrong");

  chk_wzs_update: assert property (
    (loc_wr && idx == 6'(`PMA_IDX_WZS) && evt_clr == '0) |=> gcfg_fields_q[`PMA_IDX_WZS] ==
      ($past(gcfg_fields_q[`PMA_IDX_WZS]) | ~$past(cur_q.wdata[FW-1:0])))
    else $error("write-zero-sets update wrong");

  chk_cct_decode: assert property (
    (take && (gnt_req.addr & `PMA_BLK_MASK) == `PMA_BASE_CCT)
      |=> per_q.sel == `PMA_NUM_EXT'(1 << `PMA_SEL_CCT) ##1 per_q.sel == '0)
    else $error("capture-compare timer not selected");

  chk_ia_decode: assert property (
    (take && (gnt_req.addr & `PMA_BLK_MASK) == `PMA_BASE_IA)
      |=> per_q.sel == `PMA_NUM_EXT'(1 << `PMA_SEL_IA))
    else $error("interrupt aggregator not selected");

  chk_ecs_decode: assert property (
    (take && (gnt_req.addr & `PMA_BLK_MASK) == `PMA_BASE_ECS)
      |=> per_q.sel == `PMA_NUM_EXT'(1 << `PMA_SEL_ECS))
    else $error("processor subsystem block not selected");

  chk_pcr_decode: assert property (
    (take && (gnt_req.addr & `PMA_BLK_MASK) == `PMA_BASE_PCR)
      |=> per_q.sel == `PMA_NUM_EXT'(1 << `PMA_SEL_PCR))
    else $error("power clock reset block not selected");

  chk_vci_decode: assert property (
    (take && (gnt_req.addr & `PMA_BLK_MASK) == `PMA_BASE_VCI)
      |=> per_q.sel == `PMA_NUM_EXT'(1 << `PMA_SEL_VCI))
    else $error("battery control interface not selected");

  chk_dbg_served: assert property (
    (dbg_req.valid && !dbg_rsp_q.done && state_q == ST_IDLE) |-> ##[1:6] dbg_rsp_q.done)
    else $error("debug request not served in time");

  chk_one_owner: assert property (
    !(cpu_rsp_q.done && dbg_rsp_q.done) && (!cpu_rsp_q.done || $past(state_q) == ST_XFER))
    else $error("two requesters completed at once");

  cov_cpu_ext_read: cover property (
    take && !gnt_dbg && !gnt_req.write && gnt_blk == pma_pkg::PMA_BLK_CCT ##2 cpu_rsp_q.done);

  cov_dbg_local_write: cover property (
    take && gnt_dbg && gnt_req.write && gnt_blk == pma_pkg::PMA_BLK_GCFG ##2 dbg_rsp_q.done);

  cov_both_request: cover property (
    (state_q == ST_IDLE && cpu_req.valid && dbg_req.valid) ##[1:8] dbg_rsp_q.done);

endmodule
`default_nettype wire
